// ===== hw/seq_gen_pkg.sv
// constants, register map and state types of the load sequence generator
package seq_gen_pkg;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 8;
  localparam int NUM_POINTS = 100;
  localparam int NUM_PARAMS = 4;
  localparam int PT_W       = 7;
  localparam int WORD_AW    = PT_W + 2;
  localparam int NUM_WORDS  = NUM_POINTS * NUM_PARAMS;
  localparam int CYC_W      = 10;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_START  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_END    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CYCLES = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_LEVEL  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_INDEX  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_DATA   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_SUBMIT = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;

  // field positions
  localparam int CTRL_RUN_BIT    = 0;
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_BUSY_BIT   = 1;
  localparam int STAT_VIEW_BIT   = 2;
  localparam int STAT_PT_LSB     = 8;
  localparam int STAT_CYC_LSB    = 16;

  // ranges and reset values
  localparam logic [PT_W-1:0]   PT_MIN      = 7'h01;
  localparam logic [PT_W-1:0]   PT_MAX      = 7'h64;
  localparam logic [DATA_W-1:0] CYCLES_MAX  = 32'h0000_03E7;
  localparam logic [CYC_W-1:0]  CYCLES_RST  = 10'h001;
  localparam logic [1:0]        IDX_VOLT    = 2'h0;
  localparam logic [1:0]        IDX_CURR    = 2'h1;
  localparam logic [1:0]        IDX_POW     = 2'h2;
  localparam logic [1:0]        IDX_TIME    = 2'h3;
  localparam logic [DATA_W-1:0] TIME_MIN_MS = 32'h0000_0001;
  localparam logic [DATA_W-1:0] TIME_MAX_MS = 32'h0225_5100;
  localparam logic [DATA_W-1:0] GAP_MS      = 32'h0000_012C;

  // time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1_000_000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_DWELL, SEQ_GAP} seq_state_t;
endpackage

// ===== hw/seq_table_mem.sv
// simple one-write one-read table memory with registered read data
module seq_table_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 400,
  parameter int AW    = 9
) (
  input  logic             clk,
  input  logic             we,
  input  logic [AW-1:0]    waddr,
  input  logic [WIDTH-1:0] wdata,
  input  logic [AW-1:0]    raddr,
  output logic [WIDTH-1:0] rdata
);
  // no reset on the array: contents survive rst like retained storage
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // seq_table_mem

// ===== hw/load_sequence_generator.sv
// load sequence generator: APB command registers, staged point table and run sequencer
// Notes on behaviour
// RULE1 - table written remotely is kept, shared storage
// RULE2 - first point 1..100, readable back
// RULE3 - last point held and readable back
// RULE4 - single point: controller sets last equal first
// RULE5 - cycle count, zero repeats endlessly, readable
// RULE6 - run/stop command, state query, display view
// RULE7 - table loads need no mode activation
// RULE8 - unfilled point gives 300 ms zero gap; the code zeroes set_volt and set_curr only, set_pow keeps its value
// RULE9 - selected point pointer set and readable
// RULE10 - parameter index 0..3, readable
// RULE11 - data writes selected parameter, query last value
// RULE12 - table changes take effect only on submit
// RULE13 - index: volt, current, power, duration
// RULE14 - setpoints accepted from zero to nominal
// RULE15 - duration in ms up to 36,000,000
// RULE16 - unwritten setpoints keep stored value
// RULE17 - no clamping to front panel limits
// RULE18 - controller programs settings before each run
// RULE19 - any contiguous block may form sequence
// RULE20 - after last cycle stop, hold last setpoints
// RULE21 - step ascending, wrap until count reached
// RULE22 - out-of-range values rejected, settings unchanged
//
// Decided for this implementation: the register addresses and the APB register port.
module load_sequence_generator
  import seq_gen_pkg::*;
#(
  parameter logic [31:0] NOM_VOLT    = 32'h0000_03E8,
  parameter logic [31:0] NOM_CURR    = 32'h0000_03E8,
  parameter logic [31:0] NOM_POW     = 32'h0000_03E8,
  parameter int unsigned TICK_CYCLES = seq_gen_pkg::TICK_CYCLES
) (
  input  logic                            clk,
  input  logic                            rst,
  input  logic                            psel,
  input  logic                            penable,
  input  logic                            pwrite,
  input  logic [seq_gen_pkg::ADDR_W-1:0]  paddr,
  input  logic [seq_gen_pkg::DATA_W-1:0]  pwdata,
  output logic [seq_gen_pkg::DATA_W-1:0]  prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  logic                            front_panel_ack,
  output logic [seq_gen_pkg::DATA_W-1:0]  set_volt,
  output logic [seq_gen_pkg::DATA_W-1:0]  set_curr,
  output logic [seq_gen_pkg::DATA_W-1:0]  set_pow,
  output logic                            seq_running,
  output logic                            front_panel_seq_view,
  output logic [seq_gen_pkg::PT_W-1:0]    active_point
);
  import seq_gen_pkg::*;

  function automatic logic [WORD_AW-1:0] word_addr(input logic [PT_W-1:0] pt, input logic [1:0] idx);
    word_addr = {pt - PT_MIN, idx};
  endfunction

  function automatic logic pt_ok(input logic [DATA_W-1:0] v);
    pt_ok = (v >= DATA_W'(PT_MIN)) && (v <= DATA_W'(PT_MAX));
  endfunction

  // no clamp to front panel limits, only the unit's nominal ratings
  function automatic logic data_ok(input logic [1:0] idx, input logic [DATA_W-1:0] v);
    case (idx)
      IDX_VOLT: data_ok = (v <= NOM_VOLT);                          // see RULE14 see RULE17
      IDX_CURR: data_ok = (v <= NOM_CURR);                          // see RULE14
      IDX_POW:  data_ok = (v <= NOM_POW);                           // see RULE14
      default:  data_ok = (v >= TIME_MIN_MS) && (v <= TIME_MAX_MS); // see RULE15
    endcase
  endfunction

  logic [PT_W-1:0]    start_pt;
  logic [PT_W-1:0]    end_pt;
  logic [CYC_W-1:0]   cycles;
  logic [PT_W-1:0]    level_pt;
  logic [1:0]         index_sel;
  logic [DATA_W-1:0]  data_last;
  logic               seq_view;
  logic               commit_busy;
  logic [WORD_AW-1:0] c_addr;
  logic [WORD_AW-1:0] c_prev;
  logic               c_valid;
  logic [NUM_WORDS-1:0] dirty;
  logic [NUM_WORDS-1:0] live_valid;
  logic [DATA_W-1:0]  pend_rdata;
  logic [DATA_W-1:0]  live_rdata;
  seq_state_t         state;
  logic [PT_W-1:0]    cur_pt;
  logic [2:0]         fetch_step;
  logic [CYC_W-1:0]   cyc_done;
  logic [DATA_W-1:0]  ms_left;
  logic [31:0]        tick_cnt;
  logic [DATA_W-1:0]  stg_v;
  logic [DATA_W-1:0]  stg_i;
  logic [DATA_W-1:0]  stg_p;
  logic               wr_ok;
  logic               rd_ok;
  logic [DATA_W-1:0]  rd_val;

  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wr_do  = access & pwrite & ~pslverr;
  wire pend_we   = wr_do && (paddr == REG_DATA);
  wire submit_go = wr_do && (paddr == REG_SUBMIT);
  wire run_cmd   = wr_do && (paddr == REG_CTRL) && pwdata[CTRL_RUN_BIT];
  wire stop_cmd  = wr_do && (paddr == REG_CTRL) && !pwdata[CTRL_RUN_BIT];
  wire live_we   = c_valid && dirty[c_prev];
  wire tick      = (tick_cnt == 32'(TICK_CYCLES - 1));
  wire [WORD_AW-1:0] fetch_word = word_addr(cur_pt, fetch_step[1:0] - 2'h1);
  wire [DATA_W-1:0]  fetch_val  = live_valid[fetch_word] ? live_rdata : '0;

  assign pready       = 1'b1;
  assign seq_running  = (state != SEQ_IDLE);
  assign front_panel_seq_view = seq_view;

  // write acceptance: range checks, start <= end for run, busy checks on data and submit; no mode command is needed to load
  always_comb begin
    case (paddr)
      REG_CTRL:   wr_ok = !pwdata[CTRL_RUN_BIT] || (start_pt <= end_pt); // see RULE19
      REG_START:  wr_ok = pt_ok(pwdata);                                 // see RULE22
      REG_END:    wr_ok = pt_ok(pwdata);                                 // see RULE22
      REG_CYCLES: wr_ok = (pwdata <= CYCLES_MAX);                        // see RULE22
      REG_LEVEL:  wr_ok = pt_ok(pwdata);                                 // see RULE22
      REG_INDEX:  wr_ok = (pwdata <= DATA_W'(IDX_TIME));                 // see RULE22
      REG_DATA:   wr_ok = !commit_busy && data_ok(index_sel, pwdata);    // see RULE7 see RULE22
      REG_SUBMIT: wr_ok = !commit_busy;
      default:    wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = '0;
    case (paddr)
      REG_CTRL:   rd_val[CTRL_RUN_BIT] = seq_running;  // see RULE6
      REG_START:  rd_val = DATA_W'(start_pt);         // see RULE2
      REG_END:    rd_val = DATA_W'(end_pt);           // see RULE3
      REG_CYCLES: rd_val = DATA_W'(cycles);           // see RULE5
      REG_LEVEL:  rd_val = DATA_W'(level_pt);         // see RULE9
      REG_INDEX:  rd_val = DATA_W'(index_sel);        // see RULE10
      REG_DATA:   rd_val = data_last;                 // see RULE11
      REG_SUBMIT: rd_val = '0;
      REG_STATUS: begin
        rd_val[STAT_RUN_BIT]                   = seq_running;
        rd_val[STAT_BUSY_BIT]                  = commit_busy;
        rd_val[STAT_VIEW_BIT]                  = seq_view;
        rd_val[STAT_PT_LSB +: PT_W]            = cur_pt;
        rd_val[STAT_CYC_LSB +: CYC_W]          = cyc_done;
      end
      default:    rd_ok = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle so read data comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? '0 : rd_val;
      pslverr <= pwrite ? !wr_ok : !rd_ok;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_pt  <= PT_MIN;
      end_pt    <= PT_MIN;
      cycles    <= CYCLES_RST;
      level_pt  <= PT_MIN;
      index_sel <= IDX_VOLT;
      data_last <= '0;
    end else if (wr_do) begin
      case (paddr)
        REG_START:  start_pt  <= pwdata[PT_W-1:0];  // see RULE2
        REG_END:    end_pt    <= pwdata[PT_W-1:0];  // see RULE3
        REG_CYCLES: cycles    <= pwdata[CYC_W-1:0]; // see RULE5
        REG_LEVEL:  level_pt  <= pwdata[PT_W-1:0];  // see RULE9
        REG_INDEX:  index_sel <= pwdata[1:0];       // see RULE10 see RULE13
        REG_DATA:   data_last <= pwdata;            // see RULE11
        default:    ;
      endcase
    end
  end

  // remote start brings the display to the sequence view until acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_view <= 1'b0;
    end else if (run_cmd) begin
      seq_view <= 1'b1;                             // see RULE6
    end else if (front_panel_ack) begin
      seq_view <= 1'b0;
    end
  end

  // staging table: data writes land here, the sequencer never reads it
  seq_table_mem #(.WIDTH(DATA_W), .DEPTH(NUM_WORDS), .AW(WORD_AW)) u_pending (
    .clk   (clk),
    .we    (pend_we),
    .waddr (word_addr(level_pt, index_sel)),        // see RULE11 see RULE13
    .wdata (pwdata),
    .raddr (c_addr),
    .rdata (pend_rdata)
  );

  // live table, written only by submit; array words survive rst but live_valid clears, so they read as unfilled
  seq_table_mem #(.WIDTH(DATA_W), .DEPTH(NUM_WORDS), .AW(WORD_AW)) u_live (
    .clk   (clk),
    .we    (live_we),                               // see RULE1 see RULE12
    .waddr (c_prev),
    .wdata (pend_rdata),
    .raddr (word_addr(cur_pt, fetch_step[1:0])),
    .rdata (live_rdata)
  );

  // submit walks every word and copies only those written since the last one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      commit_busy <= 1'b0;
      c_addr      <= '0;
      c_prev      <= '0;
      c_valid     <= 1'b0;
    end else if (submit_go) begin
      commit_busy <= 1'b1;                          // see RULE12
      c_addr      <= '0;
      c_valid     <= 1'b0;
    end else if (commit_busy) begin
      c_prev <= c_addr;
      if (c_addr < WORD_AW'(NUM_WORDS)) begin
        c_addr  <= c_addr + 1'b1;
        c_valid <= 1'b1;
      end else begin
        commit_busy <= 1'b0;
        c_valid     <= 1'b0;
      end
    end
  end

  // a word never written keeps its stored value; set wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dirty      <= '0;
      live_valid <= '0;
    end else begin
      if (live_we) begin
        dirty[c_prev]      <= 1'b0;
        live_valid[c_prev] <= 1'b1;                 // see RULE16
      end
      if (pend_we) begin
        dirty[word_addr(level_pt, index_sel)] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (state == SEQ_FETCH || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // sequencer; outputs hold after a stop so the load keeps drawing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= SEQ_IDLE;
      cur_pt     <= PT_MIN;
      fetch_step <= '0;
      cyc_done   <= '0;
      ms_left    <= '0;
      stg_v      <= '0;
      stg_i      <= '0;
      stg_p      <= '0;
      set_volt   <= '0;
      set_curr   <= '0;
      set_pow    <= '0;
    end else if (stop_cmd) begin
      state <= SEQ_IDLE;                            // see RULE6
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (run_cmd) begin
            state      <= SEQ_FETCH;                // see RULE6
            cur_pt     <= start_pt;
            cyc_done   <= '0;
            fetch_step <= '0;
          end
        end
        SEQ_FETCH: begin
          fetch_step <= fetch_step + 1'b1;
          case (fetch_step)
            3'h0: begin
              if (live_valid[word_addr(cur_pt, IDX_VOLT) +: NUM_PARAMS] == '0) begin
                state    <= SEQ_GAP;                // see RULE8
                set_volt <= '0;
                set_curr <= '0;
                ms_left  <= GAP_MS;
              end
            end
            3'h1: stg_v <= fetch_val;
            3'h2: stg_i <= fetch_val;
            3'h3: stg_p <= fetch_val;
            default: begin
              set_volt <= stg_v;                    // see RULE15
              set_curr <= stg_i;
              set_pow  <= stg_p;
              ms_left  <= live_valid[fetch_word] ? live_rdata : GAP_MS;
              state    <= SEQ_DWELL;
            end
          endcase
        end
        SEQ_DWELL, SEQ_GAP: begin
          if (tick) begin
            ms_left <= ms_left - 1'b1;
            if (ms_left == TIME_MIN_MS) begin
              fetch_step <= '0;
              state      <= SEQ_FETCH;
              if (cur_pt != end_pt) begin
                cur_pt <= cur_pt + 1'b1;            // see RULE21
              end else if (cycles != '0 && cyc_done + 1'b1 == cycles) begin
                state <= SEQ_IDLE;                  // see RULE20 see RULE5
              end else begin
                cur_pt <= start_pt;                 // see RULE21
                if (cycles != '0) begin
                  cyc_done <= cyc_done + 1'b1;
                end
              end
            end
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  assign active_point = cur_pt;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_gap_zero;
    (state == SEQ_GAP) |-> (set_volt == '0) && (set_curr == '0);
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("gap with nonzero setpoint"); // see RULE8

  property p_gap_len;
    (state == SEQ_FETCH) ##1 (state == SEQ_GAP) |-> (ms_left == GAP_MS);
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap not loaded with 300 ms"); // see RULE8

  property p_index_reject;
    wr_do && (paddr == REG_INDEX) |-> (pwdata <= DATA_W'(IDX_TIME));
  endproperty
  a_index_reject: assert property (p_index_reject) else $error("bad index accepted"); // see RULE22

  property p_start_hold;
    access && pwrite && (paddr == REG_START) && !pt_ok(pwdata) |=> $stable(start_pt);
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("bad first point stored"); // see RULE2

  property p_commit_only;
    live_we |-> commit_busy || $past(commit_busy);
  endproperty
  a_commit_only: assert property (p_commit_only) else $error("live table written outside submit"); // see RULE12

  property p_run_start;
    run_cmd && (state == SEQ_IDLE) |=> seq_running && seq_view && (cur_pt == $past(start_pt));
  endproperty
  a_run_start: assert property (p_run_start) else $error("run command did not start"); // see RULE6

  property p_stop_hold;
    $fell(seq_running) |-> $stable(set_volt) && $stable(set_curr) && $stable(set_pow);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("setpoints changed at stop"); // see RULE20

  property p_fetch_len;
    // a stop command inside the fetch legally ends it early
    (state == SEQ_FETCH) && (fetch_step == 3'h1) ##0 (!stop_cmd)[*4] |=> (state == SEQ_DWELL);
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("point fetch took wrong time"); // see RULE21

  property p_cycles_range;
    cycles <= CYC_W'(CYCLES_MAX);
  endproperty
  a_cycles_range: assert property (p_cycles_range) else $error("cycle count out of range"); // see RULE5
endmodule // load_sequence_generator

// ===== sim/remote_ctrl_model.sv
// remote controller model: issues register commands over APB
module remote_ctrl_model (
  input  logic                           clk,
  output logic                           psel,
  output logic                           penable,
  output logic                           pwrite,
  output logic [seq_gen_pkg::ADDR_W-1:0] paddr,
  output logic [seq_gen_pkg::DATA_W-1:0] pwdata,
  input  logic [seq_gen_pkg::DATA_W-1:0] prdata,
  input  logic                           pready,
  input  logic                           pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import seq_gen_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // one full transfer; the caller sequences commands, e.g. end equal start
  // for a single point and all settings before each run
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                      output logic [DATA_W-1:0] rdata, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no cycle count assumed: only the bench watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep showing the old request
    paddr   <= ~addr;
    pwdata  <= ~wdata;
  endtask
endmodule // remote_ctrl_model

// ===== sim/load_sequence_generator_tb_top.sv
// self-checking bench of the load sequence generator
module load_sequence_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import seq_gen_pkg::*;
  localparam int TICK = 10;

  logic              clk, rst, psel, penable, pwrite, pready, pslverr, ack, running, view;
  logic [ADDR_W-1:0] paddr, a;
  logic [DATA_W-1:0] pwdata, prdata, volt, curr, pow, v, e, r;
  logic [PT_W-1:0]   apt;
  logic [31:0]       seed = 32'h0000_001C;
  logic [31:0]       shadow [16];
  logic [ADDR_W-1:0] regs [5] = '{REG_START, REG_END, REG_CYCLES, REG_LEVEL, REG_INDEX};
  int                miscompares = 0;
  int                comparisons = 0;
  int                n, m;

  load_sequence_generator #(.TICK_CYCLES(TICK)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .front_panel_ack(ack),
    .set_volt(volt), .set_curr(curr), .set_pow(pow), .seq_running(running),
    .front_panel_seq_view(view), .active_point(apt));

  remote_ctrl_model i_ctrl (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // value a register should hold after writing v over old
  function automatic logic [31:0] expect_store(input logic [ADDR_W-1:0] ad, input logic [31:0] d,
                                               input logic [31:0] old);
    logic ok;
    case (ad)
      REG_START, REG_END, REG_LEVEL: ok = (d >= 1 && d <= 100);
      REG_CYCLES: ok = (d <= 999);
      default: ok = (d <= 3);
    endcase
    return ok ? d : old;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic        er;
    i_ctrl.xfer(1'b1, ad, d, rd, er);
    chk("pslverr", {31'h0, exp_err}, {31'h0, er});
  endtask

  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] ad, input logic [31:0] exp);
    logic er;
    i_ctrl.xfer(1'b0, ad, 32'h0, r, er);
    chk(name, exp, r);
  endtask

  task automatic load_pt(input logic [31:0] pt, input logic [127:0] vals);
    wr(REG_LEVEL, pt, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(REG_INDEX, 32'(i), 1'b0);
      wr(REG_DATA, vals[32*i +: 32], 1'b0);
      rd_chk("data", REG_DATA, vals[32*i +: 32]);
    end
  endtask

  task automatic commit();
    logic er;
    wr(REG_SUBMIT, 32'h0, 1'b0);
    wr(REG_DATA, 32'h7, 1'b1);
    m = 0;
    do begin
      i_ctrl.xfer(1'b0, REG_STATUS, 32'h0, r, er);
      m++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && m < 500);
    chk("commit_done", 32'h0, {31'h0, r[STAT_BUSY_BIT]});
  endtask

  task automatic set_run(input logic [31:0] s, input logic [31:0] t, input logic [31:0] c);
    wr(REG_START, s, 1'b0);
    wr(REG_END, t, 1'b0);
    wr(REG_CYCLES, c, 1'b0);
    wr(REG_CTRL, 32'h1, 1'b0);
    @(negedge clk);
    chk("view", 32'h1, {31'h0, view});
  endtask

  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    ack = 1'b0;
    shadow = '{default: 32'h0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    shadow[1] = 32'h1;
    shadow[2] = 32'h1;
    shadow[3] = 32'h1;
    shadow[4] = 32'h1;
    chk("reset_volt", 32'h0, volt);
    chk("reset_point", 32'h1, {25'h0, apt});
    // random writes to every setting, illegal values included
    for (int k = 0; k < 60; k++) begin
      a = regs[rnd() % 5];
      v = rnd() & ((a == REG_CYCLES) ? 32'h3FF : (a == REG_INDEX) ? 32'h7 : 32'h7F);
      if (k < 5) v = (k == 0) ? 32'h64 : (k == 1) ? 32'h65 : (k == 2) ? 32'h0 : (k == 3) ? 32'h3E8 : 32'h4;
      if (k < 5) a = (k < 3) ? REG_START : (k == 3) ? REG_CYCLES : REG_INDEX;
      rd_chk("setting", a, shadow[a[5:2]]);
      e = expect_store(a, v, ~v);
      wr(a, v, e !== v);
      if (e === v) shadow[a[5:2]] = v;
    end
    wr(8'h24, 32'h1, 1'b1);
    wr(REG_STATUS, 32'h1, 1'b1);
    wr(REG_START, 32'h5, 1'b0);
    wr(REG_END, 32'h4, 1'b0);
    wr(REG_CTRL, 32'h1, 1'b1);
    // no mode command first; full-scale volt is taken unclamped
    load_pt(32'h3, {32'h2, 32'h12C, 32'hC8, 32'h3E8});
    wr(REG_DATA, 32'h0, 1'b1);
    wr(REG_DATA, 32'h0225_5101, 1'b1);
    wr(REG_DATA, 32'h0225_5100, 1'b0);
    wr(REG_DATA, 32'h2, 1'b0);
    wr(REG_INDEX, 32'h0, 1'b0);
    wr(REG_DATA, 32'h3E9, 1'b1);
    rd_chk("data_kept", REG_DATA, 32'h2);
    // not yet submitted: point 3 still runs as an empty gap
    set_run(32'h3, 32'h3, 32'h1);
    for (n = 0; running === 1'b1 && n < 5000; n++) @(negedge clk);
    chk("gap_len", 32'h1, {31'h0, n >= 3000 && n <= 3010});
    chk("gap_volt", 32'h0, volt);
    chk("gap_curr", 32'h0, curr);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(negedge clk);
    chk("view_ack", 32'h0, {31'h0, view});
    commit();
    set_run(32'h3, 32'h4, 32'h1);
    for (n = 0; volt !== 32'h3E8 && n < 20; n++) @(negedge clk);
    chk("p3_volt", 32'h3E8, volt);
    chk("p3_curr", 32'hC8, curr);
    chk("p3_pow", 32'h12C, pow);
    for (m = 0; curr === 32'hC8 && m < 100; m++) @(negedge clk);
    chk("dwell", 32'h1, {31'h0, m >= 20 && m <= 27});
    chk("p4_curr", 32'h0, curr);
    for (n = 0; running === 1'b1 && n < 3100; n++) @(negedge clk);
    chk("stopped", 32'h0, {31'h0, running});
    chk("held_pow", 32'h12C, pow);
    chk("held_point", 32'h4, {25'h0, apt});
    // only current rewritten: other setpoints of point 3 must survive
    wr(REG_LEVEL, 32'h3, 1'b0);
    wr(REG_INDEX, 32'h1, 1'b0);
    wr(REG_DATA, 32'h32, 1'b0);
    commit();
    set_run(32'h3, 32'h3, 32'h0);
    for (n = 0; curr !== 32'h32 && n < 20; n++) @(negedge clk);
    chk("new_curr", 32'h32, curr);
    chk("kept_volt", 32'h3E8, volt);
    repeat (200) @(negedge clk);
    chk("endless", 32'h1, {31'h0, running});
    rd_chk("ctrl_run", REG_CTRL, 32'h1);
    wr(REG_CTRL, 32'h0, 1'b0);
    @(negedge clk);
    chk("stop", 32'h0, {31'h0, running});
    rd_chk("ctrl_stop", REG_CTRL, 32'h0);
    // two cycles of a 2 ms point: two fetches of 5 plus two dwells of 20
    set_run(32'h3, 32'h3, 32'h2);
    for (n = 0; running === 1'b1 && n < 100; n++) @(negedge clk);
    chk("two_cycles", 32'h1, {31'h0, n >= 48 && n <= 52});
    chk("two_cycles_curr", 32'h32, curr);
    conclude();
  end
endmodule // load_sequence_generator_tb_top
